// ### pkg/cges_pkg.sv
package cges_pkg;
  // Register indices on the plain port
  localparam logic [3:0] ADDR_GUARD_TIME = 4'h0;
  localparam logic [3:0] ADDR_LIFE_FACTOR = 4'h1;
  localparam logic [3:0] ADDR_HB_CONS = 4'h2;
  localparam logic [3:0] ADDR_HB_PROD = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EMCY_CODE = 4'h5;
  localparam logic [3:0] ADDR_ERR_COUNT = 4'h6;
  localparam logic [3:0] ADDR_APPLY = 4'h7;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] HB_STEP_MS = 16'h0004;
  // Emergency and internal error codes
  localparam logic [15:0] WARN_RX_OVF = 16'h4501;
  localparam logic [15:0] WARN_LIFE = 16'h4508;
  localparam logic [15:0] EMCY_RX_OVF = 16'h8110;
  localparam logic [15:0] EMCY_LIFE = 16'h8130;
  localparam logic [15:0] EMCY_T1 = 16'hFF01;
  localparam logic [15:0] EMCY_T2 = 16'hFF02;
  localparam logic [15:0] EMCY_T3 = 16'hFF03;
  localparam logic [15:0] EMCY_T4 = 16'h0000;
  localparam logic [7:0] ERR_REG_CAN = 8'h11;
  localparam logic [7:0] ERR_REG_DEV = 8'h81;
  localparam logic [7:0] ERR_REG_NONE = 8'h00;
  localparam logic [7:0] DIAG_RX_OVF = 8'h01;
  localparam logic [7:0] DIAG_ZERO = 8'h00;
  // Network status indicator modes
  localparam logic [1:0] NSI_OFF = 2'h0;
  localparam logic [1:0] NSI_GREEN = 2'h1;
  localparam logic [1:0] NSI_FLASH_RED = 2'h2;
  // Status register bit positions
  localparam int ST_LG_ACT = 0;
  localparam int ST_CABLE = 1;
  localparam int ST_EMCY_ERR = 2;
  localparam int ST_CFG_BAD = 3;
  localparam int ST_HB_CONS = 4;
  typedef enum logic {CGES_ERR_FREE = 1'b0, CGES_ERR_PRESENT = 1'b1} cges_emcy_t;
endpackage : cges_pkg

// ### src/cges_top.sv
`timescale 1ns/100ps
// Operation
// - Life guarding interval comes from guard time and life time factor.
// - No guard request within interval raises cable break and flashing red.
// - Life guarding active only when guard time and factor both nonzero.
// - Supervision starts at first guard request, stops on communication reset.
// - Nonzero consumer time makes the device detect cable break itself.
// - Producer only sends cyclic heartbeats and detects no cable break.
// - Heartbeat and guarding together is a forbidden configuration; ST_CFG_BAD is set only if guarding, consumer and producer are all set, or none is.
// - Guarding configuration changes take effect only after full restart.
// - Master polls device cyclically; device must answer in time.
// - CAN faults go to controller module as internal safety bus errors.
// - Emergency object sent on each CAN error or error state.
// - Two emergency states; emergencies emitted only on transitions.
// - Four transitions: enter, stay on clear, stay on new, leave.
// - Emergency error code reflects current emergency state.
// - Rx overflow gives 0x4501 and emergency 0x8110, 0x11, diag 1.
// - Heartbeat loss sends life emergency, zeroes inputs, flags cable break.
// - Producer period rounded up to next multiple of four milliseconds.
// - Guard or heartbeat loss gives 0x4508 and emergency 0x8130, 0x11.
module cges_top #(
  parameter int CYC_MS = cges_pkg::CYC_PER_MS,
  parameter int ERR_CNT_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic GUARD_REQ,
  input wire logic COMM_RESET,
  input wire logic HB_RX,
  input wire logic RX_OVF,
  input wire logic [6:0] NMT_STATE,
  input wire logic ERR_IN,
  input wire logic ERR_OUT,
  input wire logic [7:0] MOD_INDEX,
  output logic GUARD_RSP,
  output logic [7:0] GUARD_RSP_DATA,
  output logic HB_TX,
  output logic EMCY_TX,
  output logic [15:0] EMCY_CODE,
  output logic [7:0] EMCY_ERR_REG,
  output logic [7:0] FIRST_DIAG_BYTE,
  output logic [7:0] LAST_DIAG_BYTE,
  output logic SB_ERR,
  output logic [15:0] SB_ERR_CODE,
  output logic INPUT_ZERO,
  output logic [1:0] NETWORK_STATUS_INDICATOR
);
  // Pin input synchronisers
  // Two stages settle each pin; the third only feeds edge detection
  logic [6:1] s1_q;
  logic [6:1] s2_q;
  logic [6:1] s3_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
    end else if (CLK_EN) begin
      s1_q <= {ERR_OUT, ERR_IN, RX_OVF, HB_RX, COMM_RESET, GUARD_REQ};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Rising edges of synchronised pins
  // Each pin edge gives a single one-cycle pulse
  logic guard_p, creset_p, hb_p, ovf_p, ein_p, eout_p;
  assign guard_p = s2_q[1] & ~s3_q[1];
  assign creset_p = s2_q[2] & ~s3_q[2];
  assign hb_p = s2_q[3] & ~s3_q[3];
  assign ovf_p = s2_q[4] & ~s3_q[4];
  assign ein_p = s2_q[5] & ~s3_q[5];
  assign eout_p = s2_q[6] & ~s3_q[6];

  // Staged configuration, active copy loaded only at start or apply
  // Timers never see a half-written pair of guard values
  logic [15:0] gt_q, lf_q, hbc_q, hbp_q;
  logic [15:0] gt_a_q, lf_a_q, hbc_a_q, hbp_a_q;
  logic apply;
  // Restart strobe obeys the enable so a frozen block ignores it
  assign apply = CLK_EN && WR && ADDR == cges_pkg::ADDR_APPLY;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      gt_q <= 16'h0000;
      lf_q <= 16'h0000;
      hbc_q <= 16'h0000;
      hbp_q <= 16'h0000;
    end else if (CLK_EN && WR) begin
      if (ADDR == cges_pkg::ADDR_GUARD_TIME) gt_q <= WDATA;
      if (ADDR == cges_pkg::ADDR_LIFE_FACTOR) lf_q <= WDATA;
      if (ADDR == cges_pkg::ADDR_HB_CONS) hbc_q <= WDATA;
      if (ADDR == cges_pkg::ADDR_HB_PROD) hbp_q <= WDATA;
    end
  end
  // Restart: active config taken at reset release or apply strobe
  // Guarding on or off changes only here, so the network side
  // re-establishes from a clean state
  logic started_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      gt_a_q <= 16'h0000;
      lf_a_q <= 16'h0000;
      hbc_a_q <= 16'h0000;
      hbp_a_q <= 16'h0000;
      started_q <= 1'b0;
    end else if (CLK_EN && (apply || !started_q)) begin
      gt_a_q <= gt_q;
      lf_a_q <= lf_q;
      hbc_a_q <= hbc_q;
      hbp_a_q <= hbp_q;
      started_q <= 1'b1;
    end
  end

  // Mode decode
  // Forbidden configurations leave guarding off rather than guess
  // Consumer may run with or without the producer
  logic lg_cfg, hbc_cfg, hbp_cfg, cfg_bad, lg_en, hbc_en;
  assign lg_cfg = gt_a_q != 16'h0000 && lf_a_q != 16'h0000;
  assign hbc_cfg = hbc_a_q != 16'h0000;
  assign hbp_cfg = hbp_a_q != 16'h0000;
  assign cfg_bad = (lg_cfg && hbc_cfg && hbp_cfg) || (!lg_cfg && !hbc_cfg && !hbp_cfg);
  assign lg_en = lg_cfg && !hbc_cfg && !hbp_cfg && !cfg_bad;
  assign hbc_en = hbc_cfg && !lg_cfg;

  // Millisecond tick
  // Prescaler restarts at apply so timers begin on a whole millisecond
  logic [31:0] pre_q;
  logic ms_tick;
  assign ms_tick = pre_q == 32'(CYC_MS - 1);
  always_ff @(posedge REF_CLK) begin
    if (RESET || apply) pre_q <= 32'h0000_0000;
    else if (CLK_EN) pre_q <= ms_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
  end

  // Life guarding timer
  // Expiry is tested on the tick that reaches the limit, so the break
  // is flagged at the end of the interval, not one millisecond later
  logic lg_act_q;
  logic [31:0] lg_ms_q;
  logic lg_exp;
  logic [31:0] lg_limit;
  assign lg_limit = gt_a_q * lf_a_q;
  assign lg_exp = lg_act_q && ms_tick && lg_ms_q + 32'h0000_0001 >= lg_limit;
  always_ff @(posedge REF_CLK) begin
    if (RESET || apply) begin
      lg_act_q <= 1'b0;
      lg_ms_q <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (creset_p) lg_act_q <= 1'b0;
      else if (guard_p && lg_en) lg_act_q <= 1'b1;
      else if (lg_exp) lg_act_q <= 1'b0;
      if (guard_p || creset_p) lg_ms_q <= 32'h0000_0000;
      else if (lg_act_q && ms_tick) lg_ms_q <= lg_ms_q + 32'h0000_0001;
    end
  end

  // Heartbeat consumer timer, armed by the first heartbeat
  // Unarmed until then, so a slow producer at power-up is no break
  logic hbc_arm_q;
  logic [15:0] hbc_ms_q;
  logic hbc_exp;
  assign hbc_exp = hbc_en && hbc_arm_q && ms_tick && hbc_ms_q + 16'h0001 >= hbc_a_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET || apply) begin
      hbc_arm_q <= 1'b0;
      hbc_ms_q <= 16'h0000;
    end else if (CLK_EN) begin
      if (hb_p && hbc_en) hbc_arm_q <= 1'b1;
      else if (hbc_exp) hbc_arm_q <= 1'b0;
      if (hb_p) hbc_ms_q <= 16'h0000;
      else if (hbc_arm_q && ms_tick) hbc_ms_q <= hbc_ms_q + 16'h0001;
    end
  end

  // Heartbeat producer, period rounded up to 4 ms steps
  // Add and mask rounding holds while the step is a power of two
  logic [17:0] hbp_per;
  logic [17:0] hbp_ms_q;
  assign hbp_per = ({2'b00, hbp_a_q} + 18'(cges_pkg::HB_STEP_MS - 16'h0001))
                   & ~18'(cges_pkg::HB_STEP_MS - 16'h0001);
  always_ff @(posedge REF_CLK) begin
    if (RESET || apply) begin
      hbp_ms_q <= 18'h00000;
      HB_TX <= 1'b0;
    end else if (CLK_EN) begin
      HB_TX <= 1'b0;
      if (hbp_cfg && !lg_cfg && ms_tick) begin
        if (hbp_ms_q + 18'h00001 >= hbp_per) begin
          hbp_ms_q <= 18'h00000;
          HB_TX <= 1'b1;
        end else hbp_ms_q <= hbp_ms_q + 18'h00001;
      end
    end
  end

  // Guard response with toggle bit
  // Toggle restarts at communication reset, as the master expects
  // Replies are withheld while heartbeat is configured
  logic toggle_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      toggle_q <= 1'b0;
      GUARD_RSP <= 1'b0;
      GUARD_RSP_DATA <= 8'h00;
    end else if (CLK_EN) begin
      GUARD_RSP <= guard_p && !hbc_cfg && !hbp_cfg;
      if (guard_p) begin
        GUARD_RSP_DATA <= {toggle_q, NMT_STATE};
        toggle_q <= ~toggle_q;
      end
      if (creset_p) toggle_q <= 1'b0;
    end
  end

  // Cable break flag, indicator and input forcing
  // Expiry and a fresh request in one cycle: the break wins
  // Indicator shows green once the block has started
  logic cable_q;
  logic cable_ev;
  assign cable_ev = lg_exp || hbc_exp;
  always_ff @(posedge REF_CLK) begin
    if (RESET || apply) begin
      cable_q <= 1'b0;
      INPUT_ZERO <= 1'b0;
      NETWORK_STATUS_INDICATOR <= cges_pkg::NSI_OFF;
    end else if (CLK_EN) begin
      if (cable_ev) cable_q <= 1'b1;
      else if (guard_p || hb_p) cable_q <= 1'b0;
      if (hbc_exp) INPUT_ZERO <= 1'b1;
      else if (hb_p) INPUT_ZERO <= 1'b0;
      if (cable_ev || cable_q) NETWORK_STATUS_INDICATOR <= cges_pkg::NSI_FLASH_RED;
      else NETWORK_STATUS_INDICATOR <= cges_pkg::NSI_GREEN;
    end
  end

  // Internal safety bus error report
  // Cable break outranks overflow when both fall in one cycle
  // Code holds until the next report
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SB_ERR <= 1'b0;
      SB_ERR_CODE <= 16'h0000;
    end else if (CLK_EN) begin
      SB_ERR <= cable_ev || ovf_p;
      if (cable_ev) SB_ERR_CODE <= cges_pkg::WARN_LIFE;
      else if (ovf_p) SB_ERR_CODE <= cges_pkg::WARN_RX_OVF;
    end
  end

  // Emergency state and pending error count
  // Count saturates; a wrapped count would strand the error state
  cges_pkg::cges_emcy_t st_q;
  logic [ERR_CNT_W-1:0] cnt_q;
  logic last_out;
  assign last_out = cnt_q == ERR_CNT_W'(1);
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_q <= cges_pkg::CGES_ERR_FREE;
      cnt_q <= '0;
    end else if (CLK_EN) begin
      if (ein_p && !eout_p) begin
        if (cnt_q != '1) cnt_q <= cnt_q + ERR_CNT_W'(1);
        st_q <= cges_pkg::CGES_ERR_PRESENT;
      end else if (eout_p && !ein_p && cnt_q != '0) begin
        cnt_q <= cnt_q - ERR_CNT_W'(1);
        if (last_out) st_q <= cges_pkg::CGES_ERR_FREE;
      end
    end
  end

  // Emergency object, CAN errors first, then state transitions
  // One frame per cycle; a lower-priority event in that cycle is lost
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      EMCY_TX <= 1'b0;
      EMCY_CODE <= cges_pkg::EMCY_T4;
      EMCY_ERR_REG <= cges_pkg::ERR_REG_NONE;
      FIRST_DIAG_BYTE <= cges_pkg::DIAG_ZERO;
      LAST_DIAG_BYTE <= cges_pkg::DIAG_ZERO;
    end else if (CLK_EN) begin
      EMCY_TX <= 1'b0;
      LAST_DIAG_BYTE <= cges_pkg::DIAG_ZERO;
      if (cable_ev) begin
        EMCY_TX <= 1'b1;
        EMCY_CODE <= cges_pkg::EMCY_LIFE;
        EMCY_ERR_REG <= cges_pkg::ERR_REG_CAN;
        FIRST_DIAG_BYTE <= cges_pkg::DIAG_ZERO;
      end else if (ovf_p) begin
        EMCY_TX <= 1'b1;
        EMCY_CODE <= cges_pkg::EMCY_RX_OVF;
        EMCY_ERR_REG <= cges_pkg::ERR_REG_CAN;
        FIRST_DIAG_BYTE <= cges_pkg::DIAG_RX_OVF;
      end else if (ein_p && !eout_p) begin
        EMCY_TX <= 1'b1;
        EMCY_CODE <= (st_q == cges_pkg::CGES_ERR_FREE) ? cges_pkg::EMCY_T1
                     : cges_pkg::EMCY_T3;
        EMCY_ERR_REG <= cges_pkg::ERR_REG_DEV;
        FIRST_DIAG_BYTE <= MOD_INDEX;
      end else if (eout_p && !ein_p && cnt_q != '0) begin
        EMCY_TX <= 1'b1;
        EMCY_CODE <= last_out ? cges_pkg::EMCY_T4 : cges_pkg::EMCY_T2;
        EMCY_ERR_REG <= last_out ? cges_pkg::ERR_REG_NONE : cges_pkg::ERR_REG_DEV;
        FIRST_DIAG_BYTE <= last_out ? cges_pkg::DIAG_ZERO : MOD_INDEX;
      end
    end
  end

  // Status word placed bit by bit at the package field positions
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[cges_pkg::ST_LG_ACT] = lg_act_q;
    status[cges_pkg::ST_CABLE] = cable_q;
    status[cges_pkg::ST_EMCY_ERR] = st_q == cges_pkg::CGES_ERR_PRESENT;
    status[cges_pkg::ST_CFG_BAD] = cfg_bad;
    status[cges_pkg::ST_HB_CONS] = hbc_en;
  end
  // Register read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge REF_CLK) begin
    if (RESET) RDATA <= 16'h0000;
    else if (CLK_EN) begin
      RDATA <= 16'h0000;
      if (RD) begin
        unique case (ADDR)
          cges_pkg::ADDR_GUARD_TIME: RDATA <= gt_q;
          cges_pkg::ADDR_LIFE_FACTOR: RDATA <= lf_q;
          cges_pkg::ADDR_HB_CONS: RDATA <= hbc_q;
          cges_pkg::ADDR_HB_PROD: RDATA <= hbp_q;
          cges_pkg::ADDR_STATUS: RDATA <= status;
          cges_pkg::ADDR_EMCY_CODE: RDATA <= EMCY_CODE;
          cges_pkg::ADDR_ERR_COUNT: RDATA <= 16'(cnt_q);
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule : cges_top

// ### test/cges_top_assertions.sv
`timescale 1ns/100ps
module cges_top_assertions (
  input logic REF_CLK,
  input logic RESET,
  input logic RX_OVF,
  input logic RD,
  input logic [15:0] RDATA,
  input logic EMCY_TX,
  input logic [15:0] EMCY_CODE,
  input logic [7:0] EMCY_ERR_REG,
  input logic [7:0] FIRST_DIAG_BYTE,
  input logic SB_ERR,
  input logic [15:0] SB_ERR_CODE,
  input logic INPUT_ZERO,
  input logic [1:0] NETWORK_STATUS_INDICATOR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Emergency frames of interest
  sequence life_emcy;
    EMCY_TX && EMCY_CODE == 16'h8130;
  endsequence
  sequence ovf_emcy;
    EMCY_TX && EMCY_CODE == 16'h8110;
  endsequence
  ovf_fields_a: assert property (ovf_emcy |-> EMCY_ERR_REG == 8'h11 &&
    FIRST_DIAG_BYTE == 8'h01) else $error("overflow emergency fields");
  life_fields_a: assert property (life_emcy |-> EMCY_ERR_REG == 8'h11 &&
    SB_ERR && SB_ERR_CODE == 16'h4508) else $error("cable emergency fields");
  life_led_a: assert property (life_emcy |-> ##[0:1]
    NETWORK_STATUS_INDICATOR == 2'h2) else $error("indicator not red");
  sb_code_a: assert property (SB_ERR |-> SB_ERR_CODE == 16'h4501 ||
    SB_ERR_CODE == 16'h4508) else $error("bad safety bus code");
  ovf_react_a: assert property ($rose(RX_OVF) |-> ##[2:6] ovf_emcy)
    else $error("overflow not reported");
  hold_code_a: assert property (!EMCY_TX |-> $stable(EMCY_CODE))
    else $error("code moved without emergency");
  end_code_a: assert property (EMCY_TX && EMCY_CODE == 16'h0000 |->
    EMCY_ERR_REG == 8'h00 && FIRST_DIAG_BYTE == 8'h00) else $error("clear fields");
  dev_reg_a: assert property (EMCY_TX && EMCY_CODE[15:8] == 8'hFF |->
    EMCY_ERR_REG == 8'h81) else $error("device error register");
  zero_cause_a: assert property ($rose(INPUT_ZERO) |-> SB_ERR_CODE == 16'h4508)
    else $error("inputs zeroed without loss");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside slot");
endmodule : cges_top_assertions

bind cges_top cges_top_assertions u_chk (.REF_CLK, .RESET, .RX_OVF, .RD, .RDATA,
  .EMCY_TX, .EMCY_CODE, .EMCY_ERR_REG, .FIRST_DIAG_BYTE, .SB_ERR, .SB_ERR_CODE,
  .INPUT_ZERO, .NETWORK_STATUS_INDICATOR);

// ### test/cges_nmt_master.sv
`timescale 1ns/100ps
module cges_nmt_master (
  input logic clk,
  input logic en,
  input logic [9:0] per,
  input logic rsp,
  output logic req,
  output int miss,
  output int last
);
  int cnt = 0;
  int cyc = 0;
  logic seen = 1'b0;
  initial req = 1'b0;
  initial miss = 0;
  initial last = 0;
  // Cyclic guard requests; a missing reply counts as a device fault
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cnt <= (en && cnt < per) ? cnt + 1 : 0;
    req <= en && cnt < 2;
    if (en && cnt == 0) last <= cyc;
    seen <= rsp ? 1'b1 : (cnt == 0 ? 1'b0 : seen);
    if (en && cnt == 8 && !seen) miss <= miss + 1;
  end
endmodule : cges_nmt_master

// ### test/cges_top_bench.sv
`timescale 1ns/100ps
module cges_top_bench;
  logic REF_CLK = 1'b0, RESET = 1'b1, CLK_EN = 1'b1, WR = 1'b0, RD = 1'b0;
  logic COMM_RESET = 1'b0, HB_RX = 1'b0, RX_OVF = 1'b0, ERR_IN = 1'b0, ERR_OUT = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [6:0] NMT_STATE = 7'h05;
  logic [7:0] MOD_INDEX = 8'h00;
  logic [15:0] RDATA, EMCY_CODE, SB_ERR_CODE, d, gt, lf, hbp;
  logic GUARD_REQ, GUARD_RSP, HB_TX, EMCY_TX, SB_ERR, INPUT_ZERO;
  logic [7:0] GUARD_RSP_DATA, EMCY_ERR_REG, FIRST_DIAG_BYTE, LAST_DIAG_BYTE;
  logic [1:0] NETWORK_STATUS_INDICATOR;
  logic m_en = 1'b0;
  logic tg_q = 1'b1;
  logic [9:0] m_per = 10'h000;
  logic [31:0] q[$];
  int n_errors = 0, cmp_count = 0, seed = 66390, cyc = 0, e_cyc = 0;
  int hb_gap = 0, hb_at = 0, tg_bad = 0, miss, last, lg, n;
  always #5 REF_CLK = ~REF_CLK;
  cges_top #(.CYC_MS(10)) u_dut (.REF_CLK, .RESET, .CLK_EN, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .GUARD_REQ, .COMM_RESET, .HB_RX, .RX_OVF, .NMT_STATE, .ERR_IN, .ERR_OUT,
    .MOD_INDEX, .GUARD_RSP, .GUARD_RSP_DATA, .HB_TX, .EMCY_TX, .EMCY_CODE, .EMCY_ERR_REG,
    .FIRST_DIAG_BYTE, .LAST_DIAG_BYTE, .SB_ERR, .SB_ERR_CODE, .INPUT_ZERO,
    .NETWORK_STATUS_INDICATOR);
  cges_nmt_master u_nmt (.clk(REF_CLK), .en(m_en), .per(m_per), .rsp(GUARD_RSP),
    .req(GUARD_REQ), .miss, .last);
  // Log emergencies, heartbeat spacing and reply toggles
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (EMCY_TX) begin
      q.push_back({EMCY_CODE, EMCY_ERR_REG, FIRST_DIAG_BYTE});
      e_cyc <= cyc;
    end
    if (HB_TX) begin
      hb_gap <= cyc - hb_at;
      hb_at <= cyc;
    end
    if (GUARD_RSP) begin
      if (GUARD_RSP_DATA[7] !== ~tg_q) tg_bad <= tg_bad + 1;
      tg_q <= GUARD_RSP_DATA[7];
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_c(input int k);
    repeat (k) @(posedge REF_CLK);
  endtask : wait_c
  task wr(input logic [3:0] a, input logic [15:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    wait_c(1);
    WR <= 1'b0;
    wait_c(1);
  endtask : wr
  task rd(input logic [3:0] a);
    ADDR <= a;
    RD <= 1'b1;
    wait_c(1);
    RD <= 1'b0;
    wait_c(1);
    d = RDATA;
  endtask : rd
  // Pulse event pins {heartbeat, comm reset, overflow, error out, error in}
  task ev(input logic [4:0] m);
    {HB_RX, COMM_RESET, RX_OVF, ERR_OUT, ERR_IN} <= m;
    wait_c(2);
    {HB_RX, COMM_RESET, RX_OVF, ERR_OUT, ERR_IN} <= 5'h00;
    wait_c(8);
  endtask : ev
  function automatic logic [23:0] exp_emcy(input int k, input int c);
    if (k >= 2 * c - 1) return 24'h000000;
    if (k >= c) return 24'hFF0281;
    return k == 0 ? 24'hFF0181 : 24'hFF0381;
  endfunction : exp_emcy
  function automatic int ceil4(input int v);
    return (v + 3) / 4 * 4;
  endfunction : ceil4
  task test_done;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    wait_c(10);
    RESET <= 1'b0;
    NMT_STATE <= 7'($random(seed));
    gt = 16'(4 + ($random(seed) & 2));
    lf = 16'(2 + ($random(seed) & 1));
    hbp = 16'(1 + ($random(seed) & 7));
    lg = gt * lf * 10;
    wait_c(2);
    // Unmapped read, refused empty config, staging until restart
    rd(4'hA);
    chk(d, 0);
    rd(cges_pkg::ADDR_STATUS);
    chk(d[cges_pkg::ST_CFG_BAD], 1'b1);
    wr(cges_pkg::ADDR_GUARD_TIME, gt);
    wr(cges_pkg::ADDR_LIFE_FACTOR, lf);
    rd(cges_pkg::ADDR_STATUS);
    chk(d[cges_pkg::ST_CFG_BAD], 1'b1);
    wr(cges_pkg::ADDR_APPLY, 16'h0000);
    rd(cges_pkg::ADDR_STATUS);
    chk(d[cges_pkg::ST_CFG_BAD], 1'b0);
    rd(cges_pkg::ADDR_GUARD_TIME);
    chk(d, gt);
    // Guarded traffic, then silence until cable break
    m_per <= 10'(lg / 2);
    m_en <= 1'b1;
    wait_c(lg * 4);
    chk(q.size(), 0);
    chk(miss, 0);
    chk(GUARD_RSP_DATA[6:0], NMT_STATE);
    chk(tg_bad, 0);
    m_en <= 1'b0;
    wait_c(lg * 2);
    chk(q.size(), 1);
    chk(q[0], 32'h81301100);
    chk(e_cyc - last > lg - 8 && e_cyc - last < lg + 18, 1'b1);
    chk(NETWORK_STATUS_INDICATOR, cges_pkg::NSI_FLASH_RED);
    // Communication reset ends supervision
    m_en <= 1'b1;
    wait_c(lg);
    m_en <= 1'b0;
    ev(5'h08);
    wait_c(lg * 3);
    chk(q.size(), 1);
    q.delete();
    ev(5'h04);
    chk(q[0], 32'h81101101);
    chk(LAST_DIAG_BYTE, 8'h00);
    // Device errors in then out
    q.delete();
    n = 1 + ($random(seed) & 3);
    MOD_INDEX <= 8'($random(seed));
    for (int k = 0; k < 2 * n; k++) begin
      ev(k < n ? 5'h01 : 5'h02);
      chk(q[k][31:8], exp_emcy(k, n));
    end
    chk(q[0][7:0], MOD_INDEX);
    ev(5'h02);
    chk(q.size(), 2 * n);
    // Frozen block misses a pin edge entirely
    CLK_EN <= 1'b0;
    ev(5'h01);
    CLK_EN <= 1'b1;
    chk(q.size(), 2 * n);
    rd(cges_pkg::ADDR_ERR_COUNT);
    chk(d, 0);
    // Heartbeat together with guarding is refused
    wr(cges_pkg::ADDR_HB_CONS, 16'h0003);
    wr(cges_pkg::ADDR_HB_PROD, hbp);
    wr(cges_pkg::ADDR_APPLY, 16'h0000);
    rd(cges_pkg::ADDR_STATUS);
    chk(d[cges_pkg::ST_CFG_BAD], 1'b1);
    wr(cges_pkg::ADDR_GUARD_TIME, 16'h0000);
    wr(cges_pkg::ADDR_APPLY, 16'h0000);
    rd(cges_pkg::ADDR_STATUS);
    chk(d[cges_pkg::ST_HB_CONS], 1'b1);
    wait_c(ceil4(hbp) * 30);
    chk(hb_gap, ceil4(hbp) * 10);
    // Heartbeat loss zeroes inputs until the next one
    q.delete();
    ev(5'h10);
    ev(5'h10);
    wait_c(60);
    chk(q[0][31:8], 24'h813011);
    chk(INPUT_ZERO, 1'b1);
    ev(5'h10);
    chk(INPUT_ZERO, 1'b0);
    test_done();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_errors++;
    test_done();
  end
endmodule : cges_top_bench
